// file: ccfcd_top.sv
// Contract
// R1 - Set D flag on counter equals register D
// R2 - Set D flag on capture into D
// R3 - Transfer controller service clears D flag
// R4 - D flag cleared by zero after one-read
// R5 - Set C flag on counter equals register C
// R6 - Set C flag on capture into C
// R7 - Transfer controller service clears C flag
// R8 - C flag cleared by zero after one-read
// R9 - Writing one never sets flags
// R10 - Channels 1, 2: bit 3 reads zero
// R11 - Channels 1, 2: bit 2 reads zero
// R12 - D flag resets to zero
// R13 - C flag resets to zero
// R14 - C request forwarded only when enabled
// R15 - Counter sixteen bits, resets to zero
// R16 - Zero write clears only after one-read
//
// The placing of the registers and the plain strobed port are this design's own decisions.
module ccfcd_top
   import ccfcd_pkg::*;
#(
   parameter int CHANNEL = 0,
   parameter int CNT_W   = 16
) (
   input  wire logic       sys_clk,
   input  wire logic       reset,
   input  wire logic [3:0] regAddr,
   input  wire logic [7:0] regWrData,
   input  wire logic       regWrite,
   input  wire logic       regRead,
   output logic [7:0]      regRdData_q,
   input  wire logic       captureC,
   input  wire logic       captureD,
   input  wire logic       xferAckC,
   input  wire logic       xferAckD,
   input  wire logic       transfer_irq_select,
   output logic            compare_irq_c_q,
   output logic            compare_irq_d_q,
   output logic            irq_q
);
   // Elaboration check: only channels 0..4, counter is 16 bits
   if (CHANNEL < 0 || CHANNEL > 4 || CNT_W != 16) begin : gBadParam
      $error("ccfcd_top: unsupported CHANNEL or CNT_W");
   end

   localparam bit HAS_CD = (CHANNEL != 1) && (CHANNEL != 2);

   // ==================================================================
   // Registers
   logic [15:0] channel_counter_q;
   logic [15:0] general_register_c_q;
   logic [15:0] general_register_d_q;
   logic [1:0]  captureMode_q;
   logic        run_q;
   logic        compare_irq_enable_c_q;
   logic        compare_irq_enable_d_q;
   logic [1:0]  evtStat_q;
   logic [1:0]  evtMask_q;
   logic        capture_compare_flag_c;
   logic        capture_compare_flag_d;

   logic wrHit;
   logic statusRead;
   logic setC;
   logic setD;
   logic clrXferC;
   logic clrXferD;
   logic wrZeroC;
   logic wrZeroD;

   assign wrHit      = regWrite && (regAddr == STATUS_OFF);
   assign statusRead = regRead && (regAddr == STATUS_OFF);

   // ==================================================================
   // Event decode; compare and capture are exclusive per register
   assign setC = HAS_CD && (captureMode_q[CFG_C_BIT]
                ? captureC                                               // R6
                : (run_q && channel_counter_q == general_register_c_q)); // R5
   assign setD = HAS_CD && (captureMode_q[CFG_D_BIT]
                ? captureD                                               // R2
                : (run_q && channel_counter_q == general_register_d_q)); // R1
   // Transfer service clears only with the select bit at zero
   assign clrXferC = xferAckC && !transfer_irq_select;                   // R7
   assign clrXferD = xferAckD && !transfer_irq_select;                   // R3
   // A written one is simply ignored
   assign wrZeroC  = wrHit && !regWrData[FLAG_C_BIT];                    // R8 R9
   assign wrZeroD  = wrHit && !regWrData[FLAG_D_BIT];                    // R4 R9

   // ==================================================================
   // Flags; absent in channels 1 and 2
   if (HAS_CD) begin : gFlags
      ccfcd_flag uFlagC (
         .sys_clk   (sys_clk),
         .reset     (reset),
         .setEvent  (setC),
         .readSeen  (statusRead),
         .writeZero (wrZeroC),
         .xferClear (clrXferC),
         .flag_q    (capture_compare_flag_c)
      );
      ccfcd_flag uFlagD (
         .sys_clk   (sys_clk),
         .reset     (reset),
         .setEvent  (setD),
         .readSeen  (statusRead),
         .writeZero (wrZeroD),
         .xferClear (clrXferD),
         .flag_q    (capture_compare_flag_d)
      );
   end else begin : gNoFlags
      assign capture_compare_flag_c = 1'b0;                              // R11
      assign capture_compare_flag_d = 1'b0;                              // R10
   end

   // ==================================================================
   // Channel counter, free running while enabled
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         channel_counter_q <= COUNTER_RST;                               // R15
      end else if (regWrite && regAddr == COUNTER_LO_OFF) begin
         channel_counter_q[7:0] <= regWrData;
      end else if (regWrite && regAddr == COUNTER_HI_OFF) begin
         channel_counter_q[15:8] <= regWrData;
      end else if (run_q) begin
         channel_counter_q <= channel_counter_q + 16'h0001;              // R15
      end
   end

   // General registers; a capture loads the counter
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         general_register_c_q <= GREG_RST;
      end else if (HAS_CD && captureMode_q[CFG_C_BIT] && captureC) begin
         general_register_c_q <= channel_counter_q;                      // R6
      end else if (regWrite && regAddr == GREG_C_LO_OFF) begin
         general_register_c_q[7:0] <= regWrData;
      end else if (regWrite && regAddr == GREG_C_HI_OFF) begin
         general_register_c_q[15:8] <= regWrData;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         general_register_d_q <= GREG_RST;
      end else if (HAS_CD && captureMode_q[CFG_D_BIT] && captureD) begin
         general_register_d_q <= channel_counter_q;                      // R2
      end else if (regWrite && regAddr == GREG_D_LO_OFF) begin
         general_register_d_q[7:0] <= regWrData;
      end else if (regWrite && regAddr == GREG_D_HI_OFF) begin
         general_register_d_q[15:8] <= regWrData;
      end
   end

   // ==================================================================
   // Control registers
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         captureMode_q          <= 2'h0;
         run_q                  <= 1'b0;
         compare_irq_enable_c_q <= 1'b0;
         compare_irq_enable_d_q <= 1'b0;
         evtMask_q              <= 2'h0;
      end else if (regWrite) begin
         case (regAddr)
            CONFIG_OFF:   captureMode_q <= regWrData[1:0];
            CTRL_OFF:     run_q <= regWrData[RUN_BIT];
            IRQ_EN_OFF: begin
               compare_irq_enable_c_q <= HAS_CD && regWrData[EN_C_BIT];
               compare_irq_enable_d_q <= HAS_CD && regWrData[EN_D_BIT];
            end
            IRQ_MASK_OFF: evtMask_q <= regWrData[1:0];
            default:      ;
         endcase
      end
   end

   // ==================================================================
   // Sticky event status, write one to clear; new event wins
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         evtStat_q <= 2'h0;
      end else begin
         for (int i = 0; i < 2; i++) begin
            if ((i == 0) ? setC : setD) begin
               evtStat_q[i] <= 1'b1;
            end else if (regWrite && regAddr == IRQ_STAT_OFF && regWrData[i]) begin
               evtStat_q[i] <= 1'b0;
            end
         end
      end
   end

   // Interrupt outputs, registered
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         compare_irq_c_q <= 1'b0;
         compare_irq_d_q <= 1'b0;
         irq_q           <= 1'b0;
      end else begin
         compare_irq_c_q <= capture_compare_flag_c && compare_irq_enable_c_q; // R14
         compare_irq_d_q <= capture_compare_flag_d && compare_irq_enable_d_q;
         irq_q           <= |(evtStat_q & evtMask_q);
      end
   end

   // ==================================================================
   // Read port, data one cycle after the strobe
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         regRdData_q <= BYTE_ZERO;
      end else if (regRead) begin
         case (regAddr)
            STATUS_OFF:     regRdData_q <= STATUS_HI
                                           | {4'h0, capture_compare_flag_d,
                                              capture_compare_flag_c, 2'h0}; // R10 R11
            IRQ_EN_OFF:     regRdData_q <= {4'h0, compare_irq_enable_d_q,
                                            compare_irq_enable_c_q, 2'h0};
            IRQ_STAT_OFF:   regRdData_q <= {6'h00, evtStat_q};
            IRQ_MASK_OFF:   regRdData_q <= {6'h00, evtMask_q};
            CONFIG_OFF:     regRdData_q <= {6'h00, captureMode_q};
            COUNTER_LO_OFF: regRdData_q <= channel_counter_q[7:0];
            COUNTER_HI_OFF: regRdData_q <= channel_counter_q[15:8];
            GREG_C_LO_OFF:  regRdData_q <= general_register_c_q[7:0];
            GREG_C_HI_OFF:  regRdData_q <= general_register_c_q[15:8];
            GREG_D_LO_OFF:  regRdData_q <= general_register_d_q[7:0];
            GREG_D_HI_OFF:  regRdData_q <= general_register_d_q[15:8];
            CTRL_OFF:       regRdData_q <= {7'h00, run_q};
            default:        regRdData_q <= BYTE_ZERO;  // Unmapped reads zero
         endcase
      end else begin
         regRdData_q <= BYTE_ZERO;
      end
   end
endmodule : ccfcd_top

// file: ccfcd_pkg.sv
package ccfcd_pkg;
   // ==================================================================
   // Register map (byte offsets on the plain register port)
   localparam logic [3:0] STATUS_OFF     = 4'h0;  // timer_status
   localparam logic [3:0] IRQ_EN_OFF     = 4'h1;  // interrupt enables
   localparam logic [3:0] IRQ_STAT_OFF   = 4'h2;  // sticky event status
   localparam logic [3:0] IRQ_MASK_OFF   = 4'h3;  // event mask
   localparam logic [3:0] CONFIG_OFF     = 4'h4;  // capture/compare mode
   localparam logic [3:0] COUNTER_LO_OFF = 4'h5;
   localparam logic [3:0] COUNTER_HI_OFF = 4'h6;
   localparam logic [3:0] GREG_C_LO_OFF  = 4'h7;
   localparam logic [3:0] GREG_C_HI_OFF  = 4'h8;
   localparam logic [3:0] GREG_D_LO_OFF  = 4'h9;
   localparam logic [3:0] GREG_D_HI_OFF  = 4'hA;
   localparam logic [3:0] CTRL_OFF       = 4'hB;  // counter run

   // ==================================================================
   // Field positions
   localparam int FLAG_C_BIT  = 2;
   localparam int FLAG_D_BIT  = 3;
   localparam int CFG_C_BIT   = 0;  // 1: register C is input capture
   localparam int CFG_D_BIT   = 1;  // 1: register D is input capture
   localparam int EN_C_BIT    = 2;
   localparam int EN_D_BIT    = 3;
   localparam int RUN_BIT     = 0;

   // ==================================================================
   // Reset values
   localparam logic [15:0] COUNTER_RST = 16'h0000;
   localparam logic [15:0] GREG_RST    = 16'hFFFF;
   localparam logic [7:0]  STATUS_HI   = 8'hC0;   // bits 7:6 read as one
   localparam logic [7:0]  BYTE_ZERO   = 8'h00;
endpackage : ccfcd_pkg

// file: ccfcd_flag.sv
// One capture/compare flag with read-then-clear tracking
module ccfcd_flag (
   input  wire logic sys_clk,
   input  wire logic reset,
   input  wire logic setEvent,
   input  wire logic readSeen,
   input  wire logic writeZero,
   input  wire logic xferClear,
   output logic      flag_q
);
   logic armed_q;

   // ==================================================================
   // Flag: set wins over every clear so no event is lost
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         flag_q <= 1'b0;                                  // R12 R13
      end else if (setEvent) begin
         flag_q <= 1'b1;                                  // R1 R2 R5 R6
      end else if (xferClear || (writeZero && armed_q)) begin
         flag_q <= 1'b0;                                  // R3 R4 R7 R8
      end
   end

   // Read-as-one record; a fresh set demands a fresh read
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         armed_q <= 1'b0;
      end else if (setEvent || xferClear || writeZero) begin
         armed_q <= 1'b0;                                 // R16
      end else if (readSeen && flag_q) begin
         armed_q <= 1'b1;                                 // R16
      end
   end
endmodule : ccfcd_flag

// file: ccfcd_checker.sv
module ccfcd_checker
   import ccfcd_pkg::*;
#(
   parameter int CHANNEL = 0,
   parameter int CNT_W   = 16
) (
   input wire logic       sys_clk,
   input wire logic       reset,
   input wire logic [3:0] regAddr,
   input wire logic [7:0] regWrData,
   input wire logic       regWrite,
   input wire logic       regRead,
   input wire logic [7:0] regRdData_q,
   input wire logic       captureC,
   input wire logic       captureD,
   input wire logic       xferAckC,
   input wire logic       xferAckD,
   input wire logic       transfer_irq_select,
   input wire logic       compare_irq_c_q,
   input wire logic       compare_irq_d_q,
   input wire logic       irq_q
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (reset);
   // ==================================================================
   // Shadows
   logic enC_q, enD_q, cfgC_q, cfgD_q, maskOn_q;
   // Track enable, mode and mask as software wrote them
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         {enD_q, enC_q, cfgD_q, cfgC_q, maskOn_q} <= 5'h00;
      end else if (regWrite) begin
         if (regAddr == IRQ_EN_OFF) {enD_q, enC_q} <= regWrData[3:2];
         if (regAddr == CONFIG_OFF) {cfgD_q, cfgC_q} <= regWrData[1:0];
         if (regAddr == IRQ_MASK_OFF) maskOn_q <= |regWrData[1:0];
      end
   end
   // ==================================================================
   // Properties
   property p_rst; $fell(reset) |-> !compare_irq_c_q && !compare_irq_d_q && !irq_q; endproperty
   a_rst: assert property (p_rst) else $error("request high after reset");
   property p_gate_c; !$past(enC_q) |-> !compare_irq_c_q; endproperty
   a_gate_c: assert property (p_gate_c) else $error("C request while disabled");
   // Channels 1 and 2 have no flags, so a capture there raises nothing
   property p_cap_c;
      (CHANNEL != 1 && CHANNEL != 2) && captureC && cfgC_q && enC_q && !regWrite
         |-> ##2 compare_irq_c_q;
   endproperty
   a_cap_c: assert property (p_cap_c) else $error("C capture did not set flag");
   property p_cap_d;
      (CHANNEL != 1 && CHANNEL != 2) && captureD && cfgD_q && enD_q && !regWrite
         |-> ##2 compare_irq_d_q;
   endproperty
   a_cap_d: assert property (p_cap_d) else $error("D capture did not set flag");
   // Only a write or a granted transfer may drop a request
   property p_fall_c;
      $fell(compare_irq_c_q) |->
         $past(regWrite, 2) || ($past(xferAckC, 2) && !$past(transfer_irq_select, 2));
   endproperty
   a_fall_c: assert property (p_fall_c) else $error("C flag dropped without cause");
   property p_fall_d;
      $fell(compare_irq_d_q) |->
         $past(regWrite, 2) || ($past(xferAckD, 2) && !$past(transfer_irq_select, 2));
   endproperty
   a_fall_d: assert property (p_fall_d) else $error("D flag dropped without cause");
   property p_rsvd;
      (CHANNEL == 1 || CHANNEL == 2) && $past(regRead) && $past(regAddr) == STATUS_OFF
         |-> regRdData_q[3:2] == 2'b00;
   endproperty
   a_rsvd: assert property (p_rsvd) else $error("reserved flag bits read nonzero");
   property p_irq_mask; !$past(maskOn_q) |-> !irq_q; endproperty
   a_irq_mask: assert property (p_irq_mask) else $error("interrupt while all masked");
endmodule : ccfcd_checker

bind ccfcd_top ccfcd_checker #(.CHANNEL(CHANNEL), .CNT_W(CNT_W)) u_chk (
   .sys_clk, .reset, .regAddr, .regWrData, .regWrite, .regRead, .regRdData_q,
   .captureC, .captureD, .xferAckC, .xferAckD, .transfer_irq_select,
   .compare_irq_c_q, .compare_irq_d_q, .irq_q);

// file: ccfcd_xfer_model.sv
module ccfcd_dtc_model (
   input  wire logic sys_clk,
   input  wire logic reset,
   input  wire logic active,
   input  wire logic reqC,
   input  wire logic reqD,
   output logic      ackC_q,
   output logic      ackD_q
);
   timeunit 1ns;
   timeprecision 1ps;
   logic seenC_q, seenD_q;
   // ==================================================================
   // One activation pulse per new request, a cycle late like a real grant
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         {ackC_q, ackD_q, seenC_q, seenD_q} <= 4'h0;
      end else begin
         ackC_q  <= active && reqC && !seenC_q;
         ackD_q  <= active && reqD && !seenD_q;
         seenC_q <= reqC;
         seenD_q <= reqD;
      end
   end
endmodule : ccfcd_dtc_model

// file: capture_compare_flags_c_d_test.sv
module capture_compare_flags_c_d_test;
   timeunit 1ns;
   timeprecision 1ps;
   import ccfcd_pkg::*;
   logic       sys_clk = 1'b0, reset = 1'b1;
   logic [3:0] regAddr = 4'h0;
   logic [7:0] regWrData = 8'h00, rdQ, rdQ1, rd0, rd1;
   logic       regWrite = 1'b0, regRead = 1'b0, captureC = 1'b0, captureD = 1'b0;
   logic       selBit = 1'b1, dtcOn = 1'b0, ackC, ackD, irqC, irqD, irqOut;
   int         err_total = 0, tests_run = 0;
   // ==================================================================
   // Clock, device under test, channel 1 twin and transfer controller
   always #4 sys_clk = ~sys_clk;
   ccfcd_top #(.CHANNEL(0)) uut (.sys_clk, .reset, .regAddr, .regWrData, .regWrite,
      .regRead, .regRdData_q(rd0), .captureC, .captureD, .xferAckC(ackC), .xferAckD(ackD),
      .transfer_irq_select(selBit), .compare_irq_c_q(irqC), .compare_irq_d_q(irqD),
      .irq_q(irqOut));
   ccfcd_top #(.CHANNEL(1)) uut1 (.sys_clk, .reset, .regAddr, .regWrData, .regWrite,
      .regRead, .regRdData_q(rd1), .captureC, .captureD, .xferAckC(ackC), .xferAckD(ackD),
      .transfer_irq_select(selBit), .compare_irq_c_q(), .compare_irq_d_q(), .irq_q());
   ccfcd_dtc_model data_transfer_controller (.sys_clk, .reset, .active(dtcOn), .reqC(irqC), .reqD(irqD),
      .ackC_q(ackC), .ackD_q(ackD));
   // ==================================================================
   // Bus and checking helpers
   task complete_run();
      $display("comparisons %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : complete_run
   task chk(input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp) begin
         err_total++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      regAddr   <= a;
      regWrData <= d;
      regWrite  <= 1'b1;
      @(posedge sys_clk);
      regWrite  <= 1'b0;
   endtask : wr
   // Data stands only in the cycle after the strobe
   task rd(input logic [3:0] a);
      @(posedge sys_clk);
      regAddr <= a;
      regRead <= 1'b1;
      @(posedge sys_clk);
      regRead <= 1'b0;
      #1 {rdQ, rdQ1} = {rd0, rd1};
   endtask : rd
   task hold(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask : hold
   // Bounded poll: a flag that never comes ends the run
   task wait_flag(input logic [7:0] m);
      int n;
      n = 0;
      rd(STATUS_OFF);
      while ((rdQ & m) !== m && n < 300) begin
         rd(STATUS_OFF);
         n++;
      end
      chk(rdQ & m, m);
      if (n >= 300) complete_run();
   endtask : wait_flag
   // ==================================================================
   // Scenarios
   task t_reset();
      rd(STATUS_OFF);
      chk(rdQ, 8'hC0);
      rd(COUNTER_LO_OFF);
      chk(rdQ, 8'h00);
      rd(COUNTER_HI_OFF);
      chk(rdQ, 8'h00);
      $display("reset test done");
   endtask : t_reset
   task t_capture();
      wr(CONFIG_OFF, 8'h03);
      wr(IRQ_EN_OFF, 8'h0C);
      @(posedge sys_clk);
      {captureC, captureD} <= 2'b11;
      @(posedge sys_clk);
      {captureC, captureD} <= 2'b00;
      wr(STATUS_OFF, 8'h00);
      rd(STATUS_OFF);
      chk(rdQ, 8'hCC);
      chk(rdQ1, 8'hC0);
      wr(IRQ_EN_OFF, 8'h08);
      hold(2);
      chk({6'h00, irqC, irqD}, 8'h01);
      wr(STATUS_OFF, 8'hFF);
      rd(STATUS_OFF);
      chk(rdQ, 8'hCC);
      wr(STATUS_OFF, 8'h00);
      rd(STATUS_OFF);
      chk(rdQ, 8'hC0);
      chk({7'h00, irqOut}, 8'h00);
      wr(IRQ_MASK_OFF, 8'h03);
      hold(2);
      chk({7'h00, irqOut}, 8'h01);
      wr(IRQ_STAT_OFF, 8'h03);
      hold(2);
      chk({7'h00, irqOut}, 8'h00);
      $display("capture test done");
   endtask : t_capture
   task t_compare();
      wr(CONFIG_OFF, 8'h00);
      wr(IRQ_EN_OFF, 8'h0C);
      wr(GREG_C_LO_OFF, 8'h20);
      wr(GREG_C_HI_OFF, 8'h00);
      wr(GREG_D_LO_OFF, 8'h40);
      wr(GREG_D_HI_OFF, 8'h00);
      dtcOn <= 1'b1;
      wr(CTRL_OFF, 8'h01);
      wait_flag(8'h04);
      wait_flag(8'h08);
      wr(CTRL_OFF, 8'h00);
      rd(STATUS_OFF);
      chk(rdQ, 8'hCC);
      $display("compare test done");
   endtask : t_compare
   task t_xfer();
      @(posedge sys_clk);
      selBit <= 1'b0;
      wr(IRQ_EN_OFF, 8'h00);
      wr(IRQ_EN_OFF, 8'h0C);
      hold(4);
      rd(STATUS_OFF);
      chk(rdQ, 8'hC0);
      $display("transfer test done");
   endtask : t_xfer
   initial begin
      repeat (2) @(posedge sys_clk);
      reset <= 1'b0;
      t_reset();
      t_capture();
      t_compare();
      t_xfer();
      complete_run();
   end
endmodule : capture_compare_flags_c_d_test
